// File: design/i2m_master.sv
`timescale 1ns/100ps
module i2m_master (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic controller_on_in,
  input wire logic [3:0] controller_config_in, // R2
  input wire logic [i2m_pkg::TAR_W-1:0] remote_address_in,
  input wire logic remote_address_write_in,
  input wire logic [i2m_pkg::ENTRY_W-1:0] data_command_in,
  input wire logic data_command_write_in,
  input wire logic [1:0] dma_control_in,
  input wire logic [i2m_pkg::AW-1:0] tx_dma_level_in,
  input wire logic [i2m_pkg::AW-1:0] rx_dma_level_in,
  input wire logic rx_read_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [i2m_pkg::TAR_W-1:0] remote_address_out,
  output logic shutdown_state_out,
  output logic [5:0] controller_state_out,
  output logic [7:0] rx_data_out,
  output logic rx_data_valid_out,
  output logic tx_dma_req_out,
  output logic rx_dma_req_out,
  output logic [i2m_pkg::PW-1:0] tx_level_out,
  output logic [i2m_pkg::PW-1:0] rx_level_out
);
  import i2m_pkg::*;

  typedef struct packed {
    logic en;
    logic [TAR_W-1:0] tar;
    logic [PW-1:0] tx_wptr;
    logic [PW-1:0] tx_rptr;
    logic [PW-1:0] rx_wptr;
    logic [PW-1:0] rx_rptr;
    logic req_s1;
    logic req_s2;
    logic act_s1;
    logic act_s2;
    logic rxt_s1;
    logic rxt_s2;
    logic rx_seen;
    logic ack_tgl;
    logic rd_wait;
    logic [XFER_W-1:0] xfer;
    logic rx_valid;
    logic [5:0] status;
    logic shut;
    logic tx_req;
    logic rx_req;
    logic [PW-1:0] tx_lvl;
    logic [PW-1:0] rx_lvl;
  } i2m_sys_s;

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic req_tgl;
    i2m_link_e st;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [1:0] stage;
    logic [8:0] shreg;
    logic [8:0] rxsh;
    logic [XFER_W-1:0] entry;
    logic dir;
    logic open;
    logic scl_low;
    logic sda_low;
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic busy;
  } i2m_link_s;

  i2m_sys_s sys_reg;
  i2m_sys_s sys_next;
  i2m_link_s lk_reg;
  i2m_link_s lk_next;
  i2m_ram_if tx_mem ();
  i2m_ram_if rx_mem ();
  logic [PW-1:0] tx_cnt;
  logic [PW-1:0] rx_cnt;

  // Next bit frame: eight data bits plus the acknowledge slot
  function automatic logic [8:0] frame_byte(input logic [1:0] stage, input logic [XFER_W-1:0] e);
    logic rw;
    logic [TAR_W-1:0] tar;
    rw = e[CMD_READ_BIT];
    tar = e[ENTRY_W +: TAR_W];
    if (stage == STG_DATA) begin
      frame_byte = rw ? {8'hff, e[STOP_BIT]} : {e[7:0], 1'b1}; // R6
    end else if (stage == STG_ADDR2) begin
      frame_byte = {tar[7:0], 1'b1};
    end else if (tar[TAR_SPECIAL_BIT]) begin
      frame_byte = {tar[TAR_START_SEL_BIT] ? START_BYTE : GCALL_BYTE, 1'b1}; // R3
    end else if (tar[TAR_WIDE_BIT]) begin
      frame_byte = {WIDE_PREFIX, tar[9:8], rw, 1'b1}; // R3
    end else begin
      frame_byte = {tar[6:0], rw, 1'b1};
    end
  endfunction

  i2m_ram u_tx_ram (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .mem_port_in(tx_mem)
  );

  i2m_ram u_rx_ram (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .mem_port_in(rx_mem)
  );

  assign tx_cnt = sys_reg.tx_wptr - sys_reg.tx_rptr;
  assign rx_cnt = sys_reg.rx_wptr - sys_reg.rx_rptr;

  // System clock side: queues, address register, DMA requests
  always_comb begin
    sys_next = sys_reg;
    tx_mem.wr_en = 1'b0;
    tx_mem.wr_addr = sys_reg.tx_wptr[AW-1:0];
    tx_mem.wr_data = data_command_in;
    tx_mem.rd_en = 1'b0;
    tx_mem.rd_addr = sys_reg.tx_rptr[AW-1:0];
    rx_mem.wr_en = 1'b0;
    rx_mem.wr_addr = sys_reg.rx_wptr[AW-1:0];
    rx_mem.wr_data = {2'h0, lk_reg.rx_byte};
    rx_mem.rd_en = 1'b0;
    rx_mem.rd_addr = sys_reg.rx_rptr[AW-1:0];
    sys_next.en = controller_on_in; // R1
    sys_next.req_s1 = lk_reg.req_tgl;
    sys_next.req_s2 = sys_reg.req_s1;
    sys_next.act_s1 = lk_reg.busy;
    sys_next.act_s2 = sys_reg.act_s1;
    sys_next.rxt_s1 = lk_reg.rx_tgl;
    sys_next.rxt_s2 = sys_reg.rxt_s1;
    sys_next.rx_valid = 1'b0;
    if (remote_address_write_in && (!sys_reg.en ||
        (controller_config_in[CFG_MASTER_BIT] && !sys_reg.act_s2 && tx_cnt == '0))) begin
      sys_next.tar = remote_address_in; // R5
    end
    if (sys_reg.en) begin
      if (data_command_write_in && tx_cnt != FIFO_FULL) begin
        tx_mem.wr_en = 1'b1; // R6
        sys_next.tx_wptr = sys_reg.tx_wptr + LEVEL_ONE;
      end
      if (sys_reg.rd_wait) begin
        sys_next.xfer = {sys_reg.tar, tx_mem.rd_data}; // R7
        sys_next.ack_tgl = ~sys_reg.ack_tgl;
        sys_next.rd_wait = 1'b0;
      end else if (sys_reg.req_s2 != sys_reg.ack_tgl && tx_cnt != '0) begin
        tx_mem.rd_en = 1'b1;
        sys_next.tx_rptr = sys_reg.tx_rptr + LEVEL_ONE;
        sys_next.rd_wait = 1'b1;
      end
      if (sys_reg.rxt_s2 != sys_reg.rx_seen && rx_cnt != FIFO_FULL) begin
        rx_mem.wr_en = 1'b1;
        sys_next.rx_wptr = sys_reg.rx_wptr + LEVEL_ONE;
      end
      if (rx_read_in && rx_cnt != '0) begin
        rx_mem.rd_en = 1'b1;
        sys_next.rx_rptr = sys_reg.rx_rptr + LEVEL_ONE;
        sys_next.rx_valid = 1'b1;
      end
    end else begin
      sys_next.tx_wptr = '0; // R4
      sys_next.tx_rptr = '0; // R4
      sys_next.rx_wptr = '0; // R4
      sys_next.rx_rptr = '0; // R4
      sys_next.rd_wait = 1'b0;
    end
    sys_next.rx_seen = sys_reg.rxt_s2;
    sys_next.status[ST_ACTIVITY] = sys_reg.act_s2 || tx_cnt != '0;
    sys_next.status[ST_TX_NOT_FULL] = tx_cnt != FIFO_FULL;
    sys_next.status[ST_TX_EMPTY] = tx_cnt == '0;
    sys_next.status[ST_RX_NOT_EMPTY] = rx_cnt != '0;
    sys_next.status[ST_RX_FULL] = rx_cnt == FIFO_FULL; // R12
    sys_next.status[ST_MASTER_ACTIVE] = sys_reg.act_s2;
    sys_next.shut = sys_reg.en || sys_reg.act_s2; // R8
    sys_next.tx_req = dma_control_in[DMA_TX_BIT] && sys_reg.en && tx_cnt <= {1'b0, tx_dma_level_in}; // R11 R13 R20
    sys_next.rx_req = dma_control_in[DMA_RX_BIT] && sys_reg.en &&
                      rx_cnt >= {1'b0, rx_dma_level_in} + LEVEL_ONE; // R11 R17 R20
    // Registered copies of the counts, equal to the pointer difference
    sys_next.tx_lvl = sys_next.tx_wptr - sys_next.tx_rptr;
    sys_next.rx_lvl = sys_next.rx_wptr - sys_next.rx_rptr;
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sys_reg <= '0;
      sys_reg.tar <= TAR_RESET;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // Link clock side: bit engine, four phases per bit
  always_comb begin
    lk_next = lk_reg;
    lk_next.en_s1 = sys_reg.en;
    lk_next.en_s2 = lk_reg.en_s1;
    lk_next.scl_s1 = scl_in;
    lk_next.scl_s2 = lk_reg.scl_s1;
    lk_next.sda_s1 = sda_in;
    lk_next.sda_s2 = lk_reg.sda_s1;
    lk_next.ack_s1 = sys_reg.ack_tgl;
    lk_next.ack_s2 = lk_reg.ack_s1;
    lk_next.busy = lk_reg.st != LK_IDLE;
    lk_next.ph = lk_reg.ph + 2'h1;
    if ((lk_reg.st == LK_IDLE || lk_reg.st == LK_HOLD) && lk_reg.en_s2 &&
        lk_reg.req_tgl == lk_reg.ack_s2 && lk_reg.ack_s2 == lk_reg.ack_seen) begin
      lk_next.req_tgl = ~lk_reg.req_tgl;
    end
    unique case (lk_reg.st)
      LK_IDLE: begin
        lk_next.ph = PH_DRIVE;
        lk_next.scl_low = 1'b0;
        lk_next.sda_low = 1'b0;
        if (lk_reg.ack_s2 != lk_reg.ack_seen) begin
          lk_next.ack_seen = lk_reg.ack_s2;
          lk_next.entry = sys_reg.xfer;
          lk_next.dir = sys_reg.xfer[CMD_READ_BIT];
          lk_next.st = LK_START;
        end
      end
      LK_HOLD: begin
        lk_next.ph = PH_DRIVE;
        lk_next.scl_low = 1'b1; // R14
        lk_next.sda_low = 1'b0;
        if (lk_reg.ack_s2 != lk_reg.ack_seen) begin
          lk_next.ack_seen = lk_reg.ack_s2;
          lk_next.entry = sys_reg.xfer;
          if (sys_reg.xfer[CMD_READ_BIT] != lk_reg.dir) begin
            lk_next.dir = sys_reg.xfer[CMD_READ_BIT]; // R7
            lk_next.st = LK_START;
          end else begin
            lk_next.stage = STG_DATA;
            lk_next.shreg = frame_byte(STG_DATA, sys_reg.xfer);
            lk_next.st = LK_SHIFT;
          end
        end else if (!lk_reg.en_s2) begin
          lk_next.st = LK_STOP;
        end
      end
      LK_START: begin
        if (lk_reg.ph == PH_DRIVE) begin
          lk_next.sda_low = 1'b0;
          lk_next.scl_low = lk_reg.open;
        end else if (lk_reg.ph == PH_RISE) begin
          lk_next.scl_low = 1'b0;
          if (!lk_reg.scl_s2) begin
            lk_next.ph = lk_reg.ph;
          end
        end else if (lk_reg.ph == PH_SAMPLE) begin
          lk_next.sda_low = 1'b1;
        end else begin
          lk_next.scl_low = 1'b1;
          lk_next.open = 1'b1;
          lk_next.stage = STG_ADDR1;
          lk_next.bitn = '0;
          lk_next.shreg = frame_byte(STG_ADDR1, lk_reg.entry);
          lk_next.st = LK_SHIFT;
        end
      end
      LK_SHIFT: begin
        if (lk_reg.ph == PH_DRIVE) begin
          lk_next.scl_low = 1'b1;
          lk_next.sda_low = !lk_reg.shreg[8];
        end else if (lk_reg.ph == PH_RISE) begin
          lk_next.scl_low = 1'b0;
          if (!lk_reg.scl_s2) begin
            lk_next.ph = lk_reg.ph;
          end
        end else if (lk_reg.ph == PH_SAMPLE) begin
          lk_next.rxsh = {lk_reg.rxsh[7:0], lk_reg.sda_s2};
        end else begin
          lk_next.scl_low = 1'b1;
          lk_next.shreg = {lk_reg.shreg[7:0], 1'b1};
          lk_next.bitn = lk_reg.bitn + 4'h1;
          if (lk_reg.bitn == LAST_BIT) begin
            lk_next.bitn = '0;
            if (lk_reg.stage != STG_DATA) begin
              if (lk_reg.rxsh[0]) begin
                lk_next.st = LK_STOP;
              end else if (lk_reg.stage == STG_ADDR1 && lk_reg.entry[ENTRY_W + TAR_WIDE_BIT] &&
                           !lk_reg.entry[ENTRY_W + TAR_SPECIAL_BIT]) begin
                lk_next.stage = STG_ADDR2;
                lk_next.shreg = frame_byte(STG_ADDR2, lk_reg.entry);
              end else begin
                lk_next.stage = STG_DATA;
                lk_next.shreg = frame_byte(STG_DATA, lk_reg.entry);
              end
            end else begin
              if (lk_reg.dir) begin
                lk_next.rx_byte = lk_reg.rxsh[8:1];
                lk_next.rx_tgl = ~lk_reg.rx_tgl;
              end
              if ((!lk_reg.dir && lk_reg.rxsh[0]) || lk_reg.entry[STOP_BIT]) begin
                lk_next.st = LK_STOP; // R19
              end else begin
                lk_next.st = LK_HOLD; // R14 R19
              end
            end
          end
        end
      end
      LK_STOP: begin
        if (lk_reg.ph == PH_DRIVE) begin
          lk_next.scl_low = 1'b1;
          lk_next.sda_low = 1'b1;
        end else if (lk_reg.ph == PH_RISE) begin
          lk_next.scl_low = 1'b0;
          if (!lk_reg.scl_s2) begin
            lk_next.ph = lk_reg.ph;
          end
        end else if (lk_reg.ph == PH_SAMPLE) begin
          lk_next.sda_low = 1'b0;
        end else begin
          lk_next.open = 1'b0;
          lk_next.st = LK_IDLE;
        end
      end
      default: begin
        lk_next.st = LK_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = lk_reg.scl_low;
  assign sda_oe_out = lk_reg.sda_low;
  assign remote_address_out = sys_reg.tar;
  assign shutdown_state_out = sys_reg.shut;
  assign controller_state_out = sys_reg.status;
  assign rx_data_out = rx_mem.rd_data[7:0];
  assign rx_data_valid_out = sys_reg.rx_valid;
  assign tx_dma_req_out = sys_reg.tx_req;
  assign rx_dma_req_out = sys_reg.rx_req;
  assign tx_level_out = sys_reg.tx_lvl;
  assign rx_level_out = sys_reg.rx_lvl;
endmodule

// File: design/i2m_pkg.sv
// Behaviour
// R1: Controller runs while enable bit 0 is 1, stops when cleared.
// R2: Config holds target speed mode in bits 2:1, target wide addressing in bit 3; the code reads only bit 0 (CFG_MASTER_BIT).
// R3: Remote address holds target address, general call or START byte, wide select bit 12.
// R4: While disabled both queues are held empty and command writes are dropped.
// R5: Remote address changes only when disabled, or master idle with empty transmit queue.
// R6: Command bit 8 clear queues a write byte; set queues a read.
// R7: Reads and writes mix freely in the queue, each run in its direction.
// R8: Shutdown flag bit 0 stays 1 until the engine has fully stopped.
// R9: Software polls the shutdown flag every ten bit periods, with a poll limit.
// R10: Software stops new master transfers before disabling, letting pending ones finish.
// R11: DMA control bits enable the transmit and receive request interfaces.
// R12: Receive and transmit queues are 64 entries deep.
// R13: Transmit request while transmit level is at or below the transmit watermark.
// R14: An empty transmit queue mid-transfer stalls the bus with clock held low.
// R15: Transmit bursts never exceed depth minus transmit watermark.
// R16: Transmit burst should equal depth minus transmit watermark.
// R17: Receive request while receive level is at or above receive watermark plus one.
// R18: DMA answers a receive request by reading a burst out.
// R19: A transfer ends with STOP only on an entry flagged for stop; the engine also sends STOP on a NACK, or when disabled while holding.
// R20: Each DMA request drops as soon as its watermark condition fails.
package i2m_pkg;
  localparam int DEPTH = 64;
  localparam int AW = 6;
  localparam int PW = 7;
  localparam int ENTRY_W = 10;
  localparam int TAR_W = 13;
  localparam int XFER_W = TAR_W + ENTRY_W;
  localparam logic [PW-1:0] FIFO_FULL = 7'h40;
  localparam logic [PW-1:0] LEVEL_ONE = 7'h01;
  localparam int CMD_READ_BIT = 8;
  localparam int STOP_BIT = 9;
  localparam int CFG_MASTER_BIT = 0;
  localparam int TAR_START_SEL_BIT = 10;
  localparam int TAR_SPECIAL_BIT = 11;
  localparam int TAR_WIDE_BIT = 12;
  localparam int DMA_TX_BIT = 0;
  localparam int DMA_RX_BIT = 1;
  localparam int ST_ACTIVITY = 0;
  localparam int ST_TX_NOT_FULL = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_RX_NOT_EMPTY = 3;
  localparam int ST_RX_FULL = 4;
  localparam int ST_MASTER_ACTIVE = 5;
  localparam logic [TAR_W-1:0] TAR_RESET = 13'h0000;
  localparam logic [7:0] GCALL_BYTE = 8'h00;
  localparam logic [7:0] START_BYTE = 8'h01;
  localparam logic [4:0] WIDE_PREFIX = 5'h1e;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] STG_ADDR1 = 2'h0;
  localparam logic [1:0] STG_ADDR2 = 2'h1;
  localparam logic [1:0] STG_DATA = 2'h2;
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_START = 3'h1,
    LK_SHIFT = 3'h3,
    LK_HOLD = 3'h2,
    LK_STOP = 3'h6
  } i2m_link_e;
endpackage

// File: design/i2m_ram.sv
`timescale 1ns/100ps
module i2m_ram (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  i2m_ram_if.ram mem_port_in
);
  import i2m_pkg::*;
  typedef struct packed {
    logic [DEPTH-1:0][ENTRY_W-1:0] cells;
    logic [ENTRY_W-1:0] rd_data;
  } i2m_ram_s;
  i2m_ram_s ram_reg;
  i2m_ram_s ram_next;

  always_comb begin
    ram_next = ram_reg;
    if (mem_port_in.wr_en) begin
      ram_next.cells[mem_port_in.wr_addr] = mem_port_in.wr_data;
    end
    if (mem_port_in.rd_en) begin
      ram_next.rd_data = ram_reg.cells[mem_port_in.rd_addr];
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ram_reg <= '0;
    end else begin
      ram_reg <= ram_next;
    end
  end

  assign mem_port_in.rd_data = ram_reg.rd_data;
endmodule

// File: design/i2m_ram_if.sv
`timescale 1ns/100ps
interface i2m_ram_if;
  logic wr_en;
  logic [i2m_pkg::AW-1:0] wr_addr;
  logic [i2m_pkg::ENTRY_W-1:0] wr_data;
  logic rd_en;
  logic [i2m_pkg::AW-1:0] rd_addr;
  logic [i2m_pkg::ENTRY_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport ram (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface

// File: verification/i2m_master_chk.sv
`timescale 1ns/100ps
module i2m_master_chk (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic controller_on_in,
  input wire logic [3:0] controller_config_in,
  input wire logic [i2m_pkg::TAR_W-1:0] remote_address_in,
  input wire logic remote_address_write_in,
  input wire logic [1:0] dma_control_in,
  input wire logic [i2m_pkg::AW-1:0] tx_dma_level_in,
  input wire logic [i2m_pkg::AW-1:0] rx_dma_level_in,
  input wire logic rx_read_in,
  input wire logic scl_oe_out,
  input wire logic sda_oe_out,
  input wire logic [i2m_pkg::TAR_W-1:0] remote_address_out,
  input wire logic shutdown_state_out,
  input wire logic rx_data_valid_out,
  input wire logic tx_dma_req_out,
  input wire logic rx_dma_req_out,
  input wire logic [i2m_pkg::PW-1:0] tx_level_out,
  input wire logic [i2m_pkg::PW-1:0] rx_level_out
);
  import i2m_pkg::*;
  logic en_q;
  logic tx_exp_q;
  logic rx_exp_q;
  logic rd_exp_q;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      en_q <= 1'b0;
      tx_exp_q <= 1'b0;
      rx_exp_q <= 1'b0;
      rd_exp_q <= 1'b0;
    end else begin
      en_q <= controller_on_in;
      tx_exp_q <= dma_control_in[DMA_TX_BIT] && en_q && (tx_level_out <= {1'b0, tx_dma_level_in});
      rx_exp_q <= dma_control_in[DMA_RX_BIT] && en_q && (rx_level_out >= {1'b0, rx_dma_level_in} + LEVEL_ONE);
      rd_exp_q <= rx_read_in && en_q && (rx_level_out != 7'h00);
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_tx_dma_req: assert property (tx_dma_req_out == tx_exp_q)
    else $error("tx dma request differs from watermark");
  a_rx_dma_req: assert property (rx_dma_req_out == rx_exp_q)
    else $error("rx dma request differs from watermark");
  a_rx_read_pulse: assert property (rx_data_valid_out == rd_exp_q)
    else $error("rx read pulse wrong");
  a_cleared_off: assert property (!controller_on_in [*3] |-> tx_level_out == 7'h00 && rx_level_out == 7'h00)
    else $error("queues not cleared while off");
  a_addr_taken: assert property (remote_address_write_in && !en_q |=> remote_address_out == $past(remote_address_in))
    else $error("address not taken while off");
  a_addr_refused: assert property (
    remote_address_write_in && en_q && (!controller_config_in[CFG_MASTER_BIT] || tx_level_out != 7'h00)
    |=> $stable(remote_address_out)) else $error("address changed while busy");
  a_shutdown_hold: assert property (en_q |=> shutdown_state_out)
    else $error("shutdown flag low while on");
  a_idle_released: assert property (!shutdown_state_out |-> !scl_oe_out && !sda_oe_out)
    else $error("bus held after shutdown");
  a_no_req_off: assert property (!en_q |=> !tx_dma_req_out && !rx_dma_req_out)
    else $error("dma request while off");
  a_depth_limit: assert property (tx_level_out <= FIFO_FULL && rx_level_out <= FIFO_FULL)
    else $error("queue level above depth");
  c_tx_req: cover property (tx_dma_req_out && tx_level_out != 7'h00);
  c_rx_pulse: cover property (rx_data_valid_out && rx_dma_req_out);
  c_shutdown: cover property ($fell(shutdown_state_out));
endmodule
bind i2m_master i2m_master_chk i2m_master_chk_i (.clk_sys_in, .reset_in, .controller_on_in, .controller_config_in,
  .remote_address_in, .remote_address_write_in, .dma_control_in, .tx_dma_level_in, .rx_dma_level_in, .rx_read_in,
  .scl_oe_out, .sda_oe_out, .remote_address_out, .shutdown_state_out, .rx_data_valid_out, .tx_dma_req_out,
  .rx_dma_req_out, .tx_level_out, .rx_level_out);

// File: verification/i2m_tgt_model.sv
`timescale 1ns/100ps
module i2m_tgt_model #(
  parameter logic [7:0] RD_BYTE = 8'h3c
) (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  output logic [7:0] addr_byte_out,
  output logic [7:0] wr_byte_out
);
  logic act = 1'b0;
  logic first = 1'b0;
  logic rd = 1'b0;
  logic ps = 1'b1;
  logic pd = 1'b1;
  logic [7:0] sh = 8'h00;
  int cnt = 0;
  initial sda_oe_out = 1'b0;
  initial addr_byte_out = 8'h00;
  initial wr_byte_out = 8'h00;
  always @(scl_in or sda_in) begin
    if (scl_in && ps && pd && !sda_in) begin
      act = 1'b1;
      first = 1'b1;
      rd = 1'b0;
      cnt = 0;
    end else if (scl_in && ps && !pd && sda_in) begin
      act = 1'b0;
      sda_oe_out = 1'b0;
    end else if (act && scl_in && !ps) begin
      sh = {sh[6:0], sda_in};
      cnt++;
    end else if (act && !scl_in && ps) begin
      if (cnt == 8) begin
        // Ack address and written bytes; master acks reads
        if (first) begin
          addr_byte_out = sh;
          rd = sh[0];
        end else if (!rd) begin
          wr_byte_out = sh;
        end
        sda_oe_out = first || !rd;
      end else if (cnt == 9) begin
        cnt = 0;
        sda_oe_out = rd && !sh[0] && !RD_BYTE[7];
        if (rd && sh[0]) begin
          rd = 1'b0;
        end
        first = 1'b0;
      end else if (rd && !first) begin
        sda_oe_out = !RD_BYTE[7-cnt];
      end
    end
    ps = scl_in;
    pd = sda_in;
  end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import i2m_pkg::*;
  logic clk_sys_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic reset_in = 1'b0;
  logic controller_on_in = 1'b0;
  logic [3:0] controller_config_in = 4'h0;
  logic [TAR_W-1:0] remote_address_in = 13'h0000;
  logic remote_address_write_in = 1'b0;
  logic [ENTRY_W-1:0] data_command_in = 10'h000;
  logic data_command_write_in = 1'b0;
  logic [1:0] dma_control_in = 2'h0;
  logic [AW-1:0] tx_dma_level_in = 6'h00;
  logic [AW-1:0] rx_dma_level_in = 6'h00;
  logic rx_read_in = 1'b0;
  logic stretch = 1'b0;
  logic scl_in, sda_in, scl_out, scl_oe_out, sda_out, sda_oe_out, tgt_oe;
  logic [TAR_W-1:0] remote_address_out;
  logic shutdown_state_out, rx_data_valid_out, tx_dma_req_out, rx_dma_req_out;
  logic [5:0] controller_state_out;
  logic [7:0] rx_data_out, addr_byte, wr_byte;
  logic [PW-1:0] tx_level_out, rx_level_out;
  int num_errors = 0;
  int checks = 0;
  int n;
  always #5 clk_sys_in = ~clk_sys_in;
  initial begin
    #33;
    forever #80 link_clk_in = ~link_clk_in;
  end
  // Open-drain wires; stretch lets the bench hold the clock low
  assign scl_in = !(scl_oe_out || stretch);
  assign sda_in = !(sda_oe_out || tgt_oe);
  i2m_master i2m_master_i (.*);
  i2m_tgt_model i2m_tgt_model_i (.scl_in(scl_in), .sda_in(sda_in), .sda_oe_out(tgt_oe),
    .addr_byte_out(addr_byte), .wr_byte_out(wr_byte));
  task tick();
    @(negedge clk_sys_in);
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic done(input int sel);
    case (sel)
      0: return tx_level_out === 7'h00;
      1: return wr_byte === 8'ha5;
      2: return rx_level_out === 7'h02;
      3: return shutdown_state_out === 1'b0;
      default: return controller_state_out[ST_MASTER_ACTIVE] === 1'b0;
    endcase
  endfunction
  task wait_on(input int sel, input int lim);
    n = 0;
    while (!done(sel) && n < lim) begin
      tick();
      n++;
    end
    if (!done(sel)) begin
      num_errors++;
      $display("[FAIL] wait %0d expected done seen timeout", sel);
      final_report();
    end
  endtask
  task push(input logic [9:0] d);
    data_command_in = d;
    data_command_write_in = 1'b1;
    tick();
    data_command_write_in = 1'b0;
    tick();
  endtask
  task set_tar(input logic [12:0] a);
    remote_address_in = a;
    remote_address_write_in = 1'b1;
    tick();
    remote_address_write_in = 1'b0;
    tick();
  endtask
  task scen_disabled();
    chk("status", {10'h000, controller_state_out}, 16'h0006);
    chk("pin levels", {14'h0000, scl_out, sda_out}, 16'h0000);
    push(10'h055);
    chk("tx level off", {9'h000, tx_level_out}, 16'h0000);
    rx_read_in = 1'b1;
    tick();
    rx_read_in = 1'b0;
    chk("no read pulse", {15'h0000, rx_data_valid_out}, 16'h0000);
  endtask
  task scen_address();
    set_tar(13'h1234);
    chk("tar off", {3'h0, remote_address_out}, 16'h1234);
    controller_on_in = 1'b1;
    repeat (3) tick();
    chk("on flag", {15'h0000, shutdown_state_out}, 16'h0001);
    set_tar(13'h0055);
    chk("tar refused", {3'h0, remote_address_out}, 16'h1234);
    controller_config_in = 4'h1;
    set_tar(13'h0050);
    chk("tar idle", {3'h0, remote_address_out}, 16'h0050);
  endtask
  task scen_tx_dma();
    stretch = 1'b1;
    dma_control_in = 2'h1;
    tx_dma_level_in = 6'h04;
    push(10'h011);
    wait_on(0, 2000);
    chk("tx req empty", {15'h0000, tx_dma_req_out}, 16'h0001);
    for (int i = 0; i < 5; i++) push(10'h022);
    chk("tx req above", {15'h0000, tx_dma_req_out}, 16'h0000);
    tx_dma_level_in = 6'h05;
    repeat (2) tick();
    chk("tx req equal", {15'h0000, tx_dma_req_out}, 16'h0001);
    for (int i = 0; i < 59; i++) push(10'h033);
    chk("tx level full", {9'h000, tx_level_out}, 16'h0040);
    chk("tx not full", {15'h0000, controller_state_out[ST_TX_NOT_FULL]}, 16'h0000);
    set_tar(13'h0077);
    chk("tar busy", {3'h0, remote_address_out}, 16'h0050);
    controller_on_in = 1'b0;
    repeat (50) tick();
    chk("tx cleared", {9'h000, tx_level_out}, 16'h0000);
    chk("still active", {15'h0000, shutdown_state_out}, 16'h0001);
    stretch = 1'b0;
    wait_on(3, 20000);
    chk("bus free", {14'h0000, scl_in, sda_in}, 16'h0003);
  endtask
  task scen_mixed();
    dma_control_in = 2'h3;
    tx_dma_level_in = 6'h00;
    rx_dma_level_in = 6'h01;
    controller_on_in = 1'b1;
    tick();
    push(10'h0a5);
    wait_on(1, 20000);
    repeat (300) tick();
    chk("stall scl", {15'h0000, scl_oe_out}, 16'h0001);
    chk("write addr", {8'h00, addr_byte}, 16'h00a0);
    push(10'h100);
    push(10'h300);
    wait_on(2, 30000);
    repeat (2) tick();
    chk("rx req", {15'h0000, rx_dma_req_out}, 16'h0001);
    chk("read addr", {8'h00, addr_byte}, 16'h00a1);
    for (int i = 0; i < 2; i++) begin
      rx_read_in = 1'b1;
      tick();
      rx_read_in = 1'b0;
      chk("rx valid", {15'h0000, rx_data_valid_out}, 16'h0001);
      chk("rx data", {8'h00, rx_data_out}, 16'h003c);
      tick();
      chk("rx req drop", {15'h0000, rx_dma_req_out}, 16'h0000);
    end
    wait_on(4, 5000);
    repeat (100) tick();
    chk("stop idle", {14'h0000, scl_in, sda_in}, 16'h0003);
  endtask
  initial begin
    #1;
    reset_in = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    tick();
    reset_in = 1'b0;
    tick();
    scen_disabled();
    scen_address();
    scen_tx_dma();
    scen_mixed();
    final_report();
  end
endmodule
